// [hw/ncg_guard.sv]
/*
 * configuration and memory checksum guard: holds the protected
 * configuration registers and the memory image, rescans both without
 * pause, and flags mismatches toward the fail-safe controller.
 * assumes a 20 MHz clock, an Avalon-MM master with word addressing,
 * and a device state supplied by the fail-safe controller.
 */
// The implementer's own choices: register access over Avalon-MM and the register offsets.
// Behaviour
// - scan config set nonstop while enabled
// - expected config checksum from writable register
// - mismatch sets config flag, forces safe
// - checksum setup accepted only in diagnostic
// - config writes rejected while active
// - poly x8+x2+x+1, init ones, msb first
// - sixteen registers form the protected set
// - memory image rescanned against stored checksum
// - memory mismatch sets flag, forces off
// - memory error latched, copied at power-up
// - self-test bit forces memory error flag
`timescale 1ns/1ps
`include "ncg_regs.svh"
module ncg_guard (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [`NCG_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [`NCG_DATA_W-1:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [`NCG_DATA_W-1:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // fail-safe controller
    input wire ncg_pkg::ncg_dev_state_t i_dev_state,
    output logic o_force_safe,
    output logic o_force_off,
    // off-state failure latch
    input wire logic i_nvm_latch_in,
    output logic o_nvm_latch_set
);
    // bus decode
    logic wr_take; // write accepted this edge
    logic cfg_hit; // address in protected set
    logic nvm_hit; // address in memory image
    logic in_diag; // device in diagnostic
    logic in_active; // device in active
    logic cfg_we; // protected register write
    logic nvm_we; // memory image write
    logic ctrl_wr; // control register write
    logic exp_wr; // expected checksum write
    logic [1:0] rd_ph_r; // read latency stage
    logic [`NCG_DATA_W-1:0] rdata_r; // read data flop
    logic [`NCG_DATA_W-1:0] rdata_nxt; // read data mux
    // software state
    logic cfg_en_r; // config checksum enabled
    logic selftest_r; // memory self-test pending
    logic nvm_arm_r; // memory image programmed
    logic [7:0] exp_crc_r; // expected config checksum
    logic [2:0] stat_r; // safety status one
    logic [2:0] stat_nxt;
    logic [2:0] stat_set; // hardware set terms
    logic [2:0] stat_clr; // software clear terms
    logic wr_rej; // refused write
    logic por_done_r; // power-up copy done
    // scanner
    logic [3:0] ptr_r; // address fed to memories
    logic [3:0] idx_r; // address of data now out
    logic scan_vld_r; // scan data valid
    logic pass_end_r; // previous cycle ended a pass
    logic cfg_pass_ok_r; // whole pass ran enabled
    logic [7:0] cfg_byte; // config scan data
    logic [7:0] nvm_byte; // memory scan data
    logic [7:0] cfg_crc; // config remainder
    logic [7:0] nvm_crc; // memory remainder
    logic [7:0] nvm_exp_r; // checksum kept in memory
    logic [7:0] cfg_bus; // config bus read data
    logic [7:0] nvm_bus; // memory bus read data
    logic cfg_cmp; // config compare this cycle
    logic nvm_cmp; // memory compare this cycle
    logic cfg_bad; // config mismatch
    logic nvm_bad; // real memory mismatch
    logic nvm_test; // self-test compare
    logic [7:0] cfg_res_r; // last config result
    logic [7:0] nvm_res_r; // last memory result
    logic off_r; // off request

    assign in_diag = (i_dev_state == ncg_pkg::NCG_DIAG);
    assign in_active = (i_dev_state == ncg_pkg::NCG_ACTIVE);
    assign wr_take = i_avs_write & i_avs_byteenable[0];
    assign cfg_hit = (i_avs_address[5:4] == `NCG_CFG_BASE >> 4);
    assign nvm_hit = (i_avs_address[5:4] == `NCG_NVM_BASE >> 4);
    // config registers freeze while active
    assign cfg_we = wr_take & cfg_hit & ~in_active;
    // memory image is only programmable in diagnostic
    assign nvm_we = wr_take & nvm_hit & in_diag;
    assign ctrl_wr = wr_take & (i_avs_address == `NCG_CTRL);
    assign exp_wr = wr_take & (i_avs_address == `NCG_EXP_CRC) & in_diag;
    // refused writes leave a sticky trace for software
    assign wr_rej = (wr_take & cfg_hit & in_active)
                  | (wr_take & nvm_hit & ~in_diag)
                  | (ctrl_wr & ~in_diag)
                  | (wr_take & (i_avs_address == `NCG_EXP_CRC) & ~in_diag);

    // reads wait two cycles: memory port flop, then the data flop
    assign o_avs_waitrequest = i_avs_read & (rd_ph_r != `NCG_RD_LAST);
    assign o_avs_readdata = rdata_r;

    // read latency counter, restarts for every new request
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_ph_r <= 2'h0;
        end else if (i_avs_read && rd_ph_r != `NCG_RD_LAST) begin
            rd_ph_r <= rd_ph_r + 2'h1;
        end else begin
            rd_ph_r <= 2'h0;
        end
    end

    // read mux, unmapped words answer zero
    always_comb begin
        rdata_nxt = '0;
        if (cfg_hit) begin
            rdata_nxt[7:0] = cfg_bus;
        end else if (nvm_hit) begin
            rdata_nxt[7:0] = nvm_bus;
        end else begin
            case (i_avs_address)
                `NCG_CTRL: rdata_nxt[2:0] = {nvm_arm_r, selftest_r, cfg_en_r};
                `NCG_EXP_CRC: rdata_nxt[7:0] = exp_crc_r;
                `NCG_STAT1: rdata_nxt[2:0] = stat_r;
                `NCG_CRC_RES: rdata_nxt[15:0] = {nvm_res_r, cfg_res_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    // read data flop loads once the memory ports have settled
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else if (rd_ph_r == 2'h1) begin
            rdata_r <= rdata_nxt;
        end
    end

    // control: enable and arm only in diagnostic, self-test anytime
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {nvm_arm_r, selftest_r, cfg_en_r} <= `NCG_CTRL_RST;
        end else begin
            if (ctrl_wr && in_diag) begin
                cfg_en_r <= i_avs_writedata[`NCG_CTRL_CFG_EN];
                nvm_arm_r <= i_avs_writedata[`NCG_CTRL_NVM_ARM];
            end
            // a software set beats the hardware clear in the same cycle
            if (ctrl_wr && i_avs_writedata[`NCG_CTRL_SELFTEST]) begin
                selftest_r <= 1'b1;
            end else if (nvm_test) begin
                selftest_r <= 1'b0;
            end
        end
    end

    // expected configuration checksum
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            exp_crc_r <= `NCG_EXP_RST;
        end else if (exp_wr) begin
            exp_crc_r <= i_avs_writedata[7:0];
        end
    end

    // protected configuration set, sixteen words
    ncg_regmem u_cfg_mem (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_we(cfg_we),
        .i_waddr(i_avs_address[3:0]),
        .i_wdata(i_avs_writedata[7:0]),
        .i_scan_addr(ptr_r),
        .o_scan_data(cfg_byte),
        .i_bus_addr(i_avs_address[3:0]),
        .o_bus_data(cfg_bus)
    );

    // memory image, last word holds its own checksum
    ncg_regmem u_nvm_mem (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_we(nvm_we),
        .i_waddr(i_avs_address[3:0]),
        .i_wdata(i_avs_writedata[7:0]),
        .i_scan_addr(ptr_r),
        .o_scan_data(nvm_byte),
        .i_bus_addr(i_avs_address[3:0]),
        .o_bus_data(nvm_bus)
    );

    // scan pointer walks upward and wraps, one word a cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_r <= 4'h0;
            idx_r <= 4'h0;
            scan_vld_r <= 1'b0;
            pass_end_r <= 1'b0;
        end else begin
            ptr_r <= ptr_r + 4'h1;
            idx_r <= ptr_r;
            scan_vld_r <= 1'b1;
            pass_end_r <= scan_vld_r && (idx_r == `NCG_LAST_IDX);
        end
    end

    // a pass counts only if checking was on from its first word
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_pass_ok_r <= 1'b0;
        end else if (!cfg_en_r) begin
            cfg_pass_ok_r <= 1'b0;
        end else if (scan_vld_r && idx_r == 4'h0) begin
            cfg_pass_ok_r <= 1'b1;
        end
    end

    // config remainder runs every cycle, even when disabled
    ncg_crc8 u_cfg_crc (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_valid(scan_vld_r),
        .i_first(idx_r == 4'h0),
        .i_data(cfg_byte),
        .o_crc(cfg_crc)
    );

    // memory remainder skips the stored checksum word
    ncg_crc8 u_nvm_crc (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_valid(scan_vld_r && idx_r != `NCG_LAST_IDX),
        .i_first(idx_r == 4'h0),
        .i_data(nvm_byte),
        .o_crc(nvm_crc)
    );

    // stored memory checksum is caught as the scan passes it
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            nvm_exp_r <= 8'h00;
        end else if (scan_vld_r && idx_r == `NCG_LAST_IDX) begin
            nvm_exp_r <= nvm_byte;
        end
    end

    // compare once per pass, in the cycle after the last word
    assign cfg_cmp = pass_end_r & cfg_pass_ok_r & cfg_en_r;
    assign cfg_bad = cfg_cmp & (cfg_crc != exp_crc_r);
    // self-test reports a failure without taking the device down
    assign nvm_cmp = pass_end_r & (nvm_arm_r | selftest_r);
    assign nvm_test = pass_end_r & selftest_r;
    assign nvm_bad = nvm_cmp & ~selftest_r & (nvm_crc != nvm_exp_r);

    // last results, for software to inspect
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_res_r <= 8'h00;
            nvm_res_r <= 8'h00;
        end else if (pass_end_r) begin
            cfg_res_r <= cfg_crc;
            nvm_res_r <= nvm_crc;
        end
    end

    // status: write one to clear, a set in the same cycle wins
    always_comb begin
        stat_set = '0;
        stat_set[`NCG_ST_CFG_ERR] = cfg_bad;
        stat_set[`NCG_ST_NVM_ERR] = nvm_bad | nvm_test
                                  | (~por_done_r & i_nvm_latch_in);
        stat_set[`NCG_ST_WR_REJ] = wr_rej;
        stat_clr = '0;
        if (wr_take && i_avs_address == `NCG_STAT1) begin
            stat_clr = i_avs_writedata[2:0];
        end
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
    end

    // status register and the one-shot power-up copy
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_r <= `NCG_STAT_RST;
            por_done_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            por_done_r <= 1'b1;
        end
    end

    // off request stays until power is cycled; it also feeds the latch
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            off_r <= 1'b0;
        end else if (nvm_bad) begin
            off_r <= 1'b1;
        end
    end
    assign o_force_off = off_r;
    assign o_nvm_latch_set = off_r;

    // safe request follows the flag only from operating states
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_force_safe <= 1'b0;
        end else begin
            o_force_safe <= stat_r[`NCG_ST_CFG_ERR]
                          & (i_dev_state == ncg_pkg::NCG_RESET || in_diag || in_active);
        end
    end

    // checks on the guard's own behaviour
    a_cfg_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cfg_bad |=> stat_r[`NCG_ST_CFG_ERR]) else $error("config flag missed");
    a_safe_request: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cfg_bad && in_diag ##1 in_diag |=> o_force_safe)
        else $error("safe request missed");
    a_active_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        in_active |-> !cfg_we) else $error("config write in active");
    a_diag_setup: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !in_diag |=> $stable(exp_crc_r) && $stable(cfg_en_r))
        else $error("setup outside diagnostic");
    a_nvm_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        nvm_bad |=> o_force_off && o_nvm_latch_set && stat_r[`NCG_ST_NVM_ERR])
        else $error("memory failure not forced off");
    a_scan_order: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        scan_vld_r |=> idx_r == $past(idx_r) + 4'h1) else $error("scan order");
    a_cfg_nonstop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cfg_en_r [*8] |-> ##[1:40] (pass_end_r || !cfg_en_r))
        else $error("config scan stalled");
    a_selftest_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(selftest_r) |-> ##[1:20] stat_r[`NCG_ST_NVM_ERR] && !o_force_off || o_force_off)
        else $error("self-test left no flag");
    a_por_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !por_done_r && i_nvm_latch_in |=> stat_r[`NCG_ST_NVM_ERR])
        else $error("power-up copy missed");
endmodule

// [hw/ncg_regs.svh]
/*
 * register offsets, field positions and reset values of the
 * configuration and memory checksum guard.
 * assumes word addressing on the register bus (one index per word).
 */
`ifndef NCG_REGS_SVH
`define NCG_REGS_SVH

// bus geometry
`define NCG_ADDR_W 6
`define NCG_DATA_W 32
// word indices of the register map
`define NCG_CFG_BASE 6'h00
`define NCG_CTRL 6'h10
`define NCG_EXP_CRC 6'h11
`define NCG_STAT1 6'h12
`define NCG_CRC_RES 6'h13
`define NCG_NVM_BASE 6'h20
// control register fields
`define NCG_CTRL_CFG_EN 0
`define NCG_CTRL_SELFTEST 1
`define NCG_CTRL_NVM_ARM 2
// status register fields
`define NCG_ST_CFG_ERR 0
`define NCG_ST_NVM_ERR 1
`define NCG_ST_WR_REJ 2
// checksum engine
`define NCG_CRC_INIT 8'hff
`define NCG_CRC_POLY 8'h07
`define NCG_LAST_IDX 4'hf
// reset values
`define NCG_CTRL_RST 3'h0
`define NCG_EXP_RST 8'h00
`define NCG_STAT_RST 3'h0
// read latency stages of the bus slave
`define NCG_RD_LAST 2'h2

`endif

// [hw/ncg_pkg.sv]
/*
 * types shared by the checksum guard modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ncg_pkg;
    // operating state reported by the fail-safe controller
    typedef enum logic [2:0] {
        NCG_OFF,
        NCG_INIT,
        NCG_RESET,
        NCG_DIAG,
        NCG_ACTIVE,
        NCG_SAFE
    } ncg_dev_state_t;
endpackage

// [hw/ncg_regmem.sv]
/*
 * sixteen byte register file with one write port and two registered
 * read ports (scanner and bus).
 * assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module ncg_regmem (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // write port
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // scanner read port
    input wire logic [3:0] i_scan_addr,
    output logic [7:0] o_scan_data,
    // bus read port
    input wire logic [3:0] i_bus_addr,
    output logic [7:0] o_bus_data
);
    logic [7:0] mem_r [16]; // register contents

    // storage: cleared at reset so the checksum starts from known data
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 16; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    // both read ports come out of flops
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_scan_data <= 8'h00;
            o_bus_data <= 8'h00;
        end else begin
            o_scan_data <= mem_r[i_scan_addr];
            o_bus_data <= mem_r[i_bus_addr];
        end
    end
endmodule

// [hw/ncg_crc8.sv]
/*
 * byte-wide crc-8 accumulator, one byte per clock.
 * assumes the caller marks the first byte of each pass.
 */
`timescale 1ns/1ps
`include "ncg_regs.svh"
module ncg_crc8 (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // byte stream
    input wire logic i_valid,
    input wire logic i_first,
    input wire logic [7:0] i_data,
    // running remainder
    output logic [7:0] o_crc
);
    // one byte through the divider, msb first, no final inversion
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic fb;
        r = c;
        for (int b = 7; b >= 0; b--) begin
            fb = r[7] ^ d[b];
            r = {r[6:0], 1'b0} ^ (fb ? `NCG_CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    // remainder restarts from all ones on the first byte
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_crc <= `NCG_CRC_INIT;
        end else if (i_valid) begin
            o_crc <= crc_step(i_first ? `NCG_CRC_INIT : o_crc, i_data);
        end
    end
endmodule

// [sim/ncg_guard_bench.sv]
/*
 * self-checking bench for the configuration and memory checksum guard.
 * assumes the design files under hw/ are compiled first and that the
 * include path reaches ncg_regs.svh; the bench plays bus master and
 * fail-safe controller itself.
 */
`timescale 1ns/1ps
`include "ncg_regs.svh"
module ncg_guard_bench;
    logic clk; // 20 MHz reference clock
    logic rst_n; // async reset, active low
    logic [5:0] av_addr; // bus word index
    logic av_read; // bus read request
    logic av_write; // bus write request
    logic [31:0] av_wdata; // bus write data
    logic [31:0] av_rdata; // bus read data
    logic av_wait; // bus waitrequest
    ncg_pkg::ncg_dev_state_t dev_state; // state we pretend the controller is in
    logic force_safe; // safe request from the guard
    logic force_off; // off request from the guard
    logic latch_in; // off-state latch content at power-up
    logic latch_set; // latch set request from the guard
    int errors; // mismatches seen
    int n_tests; // comparisons made
    logic [7:0] cfg_v [16]; // shadow of the protected set
    logic [7:0] nvm_v [15]; // shadow of the memory image
    logic [7:0] cfg_crc; // expected config checksum
    logic [7:0] nvm_crc; // expected memory checksum
    logic [31:0] rd; // scratch read value

    ncg_guard ncg_guard_i (
        .i_ref_clk(clk),
        .i_rst_n(rst_n),
        .i_avs_address(av_addr),
        .i_avs_read(av_read),
        .i_avs_write(av_write),
        .i_avs_writedata(av_wdata),
        .i_avs_byteenable(4'hf),
        .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait),
        .i_dev_state(dev_state),
        .o_force_safe(force_safe),
        .o_force_off(force_off),
        .i_nvm_latch_in(latch_in),
        .o_nvm_latch_set(latch_set)
    );

    // free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // one comparison; four-state equality so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask

    // bench-side crc step: msb first, poly 0x07, no final inversion
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[7] ^ b[i];
            c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // bus write; the edge with waitrequest low is the one that takes it
    task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
        av_addr <= a;
        av_wdata <= {24'h000000, d};
        av_write <= 1'b1;
        @(posedge clk iff av_wait === 1'b0);
        av_write <= 1'b0;
        @(posedge clk); // idle edge so the strobe is never reassigned in one step
    endtask

    // bus read; data taken at the same edge that sees waitrequest low
    task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
        av_addr <= a;
        av_read <= 1'b1;
        @(posedge clk iff av_wait === 1'b0);
        d = av_rdata;
        av_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus_rd(a, rd);
        chk(rd, exp);
    endtask

    // reset held 16 cycles; the latch input is sampled right after release
    task automatic do_reset(input logic l);
        rst_n <= 1'b0;
        latch_in <= l;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // reset values and an unmapped word
    task automatic t_reset;
        rd_chk(`NCG_CTRL, 32'h0);
        rd_chk(`NCG_EXP_CRC, 32'h0);
        rd_chk(`NCG_STAT1, 32'h0);
        rd_chk(6'h3f, 32'h0);
    endtask

    // checksum setup outside the diagnostic state is refused
    task automatic t_setup_refused;
        dev_state <= ncg_pkg::NCG_ACTIVE;
        bus_wr(`NCG_CTRL, 8'h01);
        bus_wr(`NCG_EXP_CRC, 8'h55);
        rd_chk(`NCG_CTRL, 32'h0);
        rd_chk(`NCG_EXP_CRC, 32'h0);
        rd_chk(`NCG_STAT1, 32'h4);
        bus_wr(`NCG_STAT1, 8'h04);
        rd_chk(`NCG_STAT1, 32'h0);
    endtask

    // good setup in diagnostic: sixteen registers, ascending, no error
    task automatic t_cfg_good;
        dev_state <= ncg_pkg::NCG_DIAG; // setup done only here
        cfg_crc = 8'hff;
        nvm_crc = 8'hff; // memory remainder still runs over the cleared image
        for (int i = 0; i < 16; i++) begin
            cfg_v[i] = 8'h3c ^ (8'(i) * 8'h1d);
            cfg_crc = crc_step(cfg_crc, cfg_v[i]);
            if (i < 15) begin
                nvm_crc = crc_step(nvm_crc, 8'h00);
            end
            bus_wr(`NCG_CFG_BASE + 6'(i), cfg_v[i]);
        end
        bus_wr(`NCG_EXP_CRC, cfg_crc);
        bus_wr(`NCG_CTRL, 8'h01);
        repeat (48) @(posedge clk); // three scan passes of 16 cycles
        rd_chk(`NCG_CRC_RES, {16'h0, nvm_crc, cfg_crc});
        rd_chk(`NCG_STAT1, 32'h0);
        chk({31'h0, force_safe}, 32'h0);
    endtask

    // configuration is locked while active, checking carries on
    task automatic t_active_lock;
        dev_state <= ncg_pkg::NCG_ACTIVE;
        bus_wr(`NCG_CFG_BASE + 6'h3, ~cfg_v[3]);
        rd_chk(`NCG_CFG_BASE + 6'h3, {24'h0, cfg_v[3]});
        rd_chk(`NCG_STAT1, 32'h4);
        repeat (48) @(posedge clk);
        chk({31'h0, force_safe}, 32'h0);
        bus_wr(`NCG_STAT1, 8'h04);
    endtask

    // wrong expected value: flag and safe request, none once safe
    task automatic t_cfg_bad;
        dev_state <= ncg_pkg::NCG_DIAG;
        bus_wr(`NCG_EXP_CRC, cfg_crc ^ 8'h01);
        for (int k = 0; k < 64 && force_safe !== 1'b1; k++) begin
            @(posedge clk);
        end
        chk({31'h0, force_safe}, 32'h1);
        rd_chk(`NCG_STAT1, 32'h1);
        dev_state <= ncg_pkg::NCG_SAFE;
        repeat (3) @(posedge clk);
        chk({31'h0, force_safe}, 32'h0);
        dev_state <= ncg_pkg::NCG_DIAG;
        bus_wr(`NCG_EXP_CRC, cfg_crc);
        repeat (48) @(posedge clk); // let a failing pass in flight finish
        bus_wr(`NCG_STAT1, 8'h01);
        rd_chk(`NCG_STAT1, 32'h0);
        repeat (3) @(posedge clk);
        chk({31'h0, force_safe}, 32'h0);
    endtask

    // memory self-test sets the flag without powering off
    task automatic t_selftest;
        bus_wr(`NCG_CTRL, 8'h03);
        repeat (48) @(posedge clk);
        rd_chk(`NCG_STAT1, 32'h2);
        chk({30'h0, force_off, latch_set}, 32'h0);
        rd_chk(`NCG_CTRL, 32'h1);
        bus_wr(`NCG_STAT1, 8'h02); // processor clears after self
        rd_chk(`NCG_STAT1, 32'h0);
    endtask

    // memory image: good checksum holds, a corrupted word powers off
    task automatic t_nvm;
        nvm_crc = 8'hff;
        for (int i = 0; i < 15; i++) begin
            nvm_v[i] = 8'ha5 + 8'(i) * 8'h0b;
            nvm_crc = crc_step(nvm_crc, nvm_v[i]);
            bus_wr(`NCG_NVM_BASE + 6'(i), nvm_v[i]);
        end
        bus_wr(`NCG_NVM_BASE + 6'hf, nvm_crc);
        bus_wr(`NCG_CTRL, 8'h05);
        repeat (48) @(posedge clk);
        chk({31'h0, force_off}, 32'h0);
        rd_chk(`NCG_CRC_RES, {16'h0, nvm_crc, cfg_crc});
        bus_wr(`NCG_NVM_BASE + 6'h5, ~nvm_v[5]);
        for (int k = 0; k < 64 && force_off !== 1'b1; k++) begin
            @(posedge clk);
        end
        chk({30'h0, force_off, latch_set}, 32'h3);
        rd_chk(`NCG_STAT1, 32'h2);
    endtask

    // next power-up copies the off-state latch into the status word
    task automatic t_powerup;
        do_reset(1'b1);
        rd_chk(`NCG_STAT1, 32'h2);
        chk({30'h0, force_off, force_safe}, 32'h0);
        latch_in <= 1'b0;
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        av_addr = 6'h00;
        av_read = 1'b0;
        av_write = 1'b0;
        av_wdata = 32'h0;
        dev_state = ncg_pkg::NCG_RESET;
        latch_in = 1'b0;
        @(posedge clk);
        do_reset(1'b0);
        t_reset();
        t_setup_refused();
        t_cfg_good();
        t_active_lock();
        t_cfg_bad();
        t_selftest();
        t_nvm();
        t_powerup();
        final_report();
    end

    // watchdog: the whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule
